/* File: common/atfs_map.svh */
/*
 * Register offsets, field positions, reset values and bus answers of the
 * axis terminal function select block.
 * Assumes inclusion by bare name from a module that uses these macros.
 */
`ifndef ATFS_MAP_SVH
`define ATFS_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ATFS_OFS_CONFIG     12'h000
`define ATFS_OFS_GPOUT      12'h004
`define ATFS_OFS_STATUS     12'h008

// ****************************************************************
// Field positions
// ****************************************************************
`define ATFS_SEL4_LSB       8
`define ATFS_SEL5_LSB       10
`define ATFS_SEL6_LSB       12
`define ATFS_SEL7_LSB       14
`define ATFS_POL0_BIT       16
`define ATFS_STAT_IN_LSB    0
`define ATFS_STAT_LVL_LSB   4
`define ATFS_STAT_OE_LSB    8

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define ATFS_CONFIG_MASK    32'h0001_FF00
`define ATFS_GPOUT_MASK     32'h0000_000F
`define ATFS_CONFIG_RST     32'h0000_0000
`define ATFS_GPOUT_RST      32'h0000_0000

// ****************************************************************
// AXI responses
// ****************************************************************
`define ATFS_RESP_OKAY      2'h0
`define ATFS_RESP_SLVERR    2'h2

`endif

/* File: common/atfs_pkg.sv */
/*
 * Types of the axis terminal function select block.
 * Assumes nothing of its surroundings.
 */
package atfs_pkg;

  // Terminal function codes as held in each two-bit selector
  typedef enum logic [1:0] {
    ATFS_GP_IN    = 2'h0,
    ATFS_GP_OUT   = 2'h1,
    ATFS_HIT_LOW  = 2'h2,
    ATFS_HIT_HIGH = 2'h3
  } atfs_func_t;

  typedef logic [1:0] atfs_resp_t;

endpackage

/* File: hdl/atfs_sync.sv */
/*
 * Two-flip-flop synchroniser for a group of pin levels.
 * Assumes aclk, synchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ps
`default_nettype none

module atfs_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             aclk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Released pin level, so no false slow-down request follows reset
      meta_q   <= '1;
      sync_out <= '1;
    end else if (aclk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/atfs_top.sv */
/*
 * Function select for multi-purpose axis terminals 4 to 7 and output
 * polarity of terminal 0, with an AXI4-Lite register slave.
 * Assumes compare hits and the terminal 0 sources come from logic on aclk;
 * terminal pin levels arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

`include "atfs_map.svh"

module atfs_top
  import atfs_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              aclk_en,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Comparator condition-satisfied levels
  input  wire logic              compare2_hit,
  input  wire logic              compare3_hit,
  input  wire logic              compare4_hit,
  input  wire logic              compare5_hit,
  // Terminal 0 sources, active high
  input  wire logic              accelerating_indicator,
  input  wire logic              oneshot_pulse,
  input  wire logic              term0_oneshot_mode,
  output var  logic              multi_terminal_0_out,
  // Multi-purpose terminals
  input  wire logic              multi_terminal_4_in,
  output var  logic              multi_terminal_4_out,
  output var  logic              multi_terminal_4_oe,
  input  wire logic              multi_terminal_5_in,
  output var  logic              multi_terminal_5_out,
  output var  logic              multi_terminal_5_oe,
  input  wire logic              multi_terminal_6_in,
  output var  logic              multi_terminal_6_out,
  output var  logic              multi_terminal_6_oe,
  input  wire logic              multi_terminal_7_in,
  output var  logic              multi_terminal_7_out,
  output var  logic              multi_terminal_7_oe,
  // Slow-down request seen on terminal 4, active low
  output var  logic              slowdown_input_n
);

  // ****************************************************************
  // Function decoding
  // ****************************************************************
  localparam int SEL_LSB [4] = '{
    `ATFS_SEL4_LSB,
    `ATFS_SEL5_LSB,
    `ATFS_SEL6_LSB,
    `ATFS_SEL7_LSB
  };

  // Returns {output enable, level} for one terminal
  function automatic logic [1:0] atfs_drive(input atfs_func_t func,
                                            input logic gp_level,
                                            input logic hit);
    logic [1:0] res;
    res = 2'h0;
    unique case (func)
      ATFS_GP_IN:    res = 2'h0;
      ATFS_GP_OUT:   res = {1'b1, gp_level};
      ATFS_HIT_LOW:  res = {1'b1, ~hit};
      ATFS_HIT_HIGH: res = {1'b1, hit};
    endcase
    return res;
  endfunction

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] atfs_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb,
                                             input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res & mask;
  endfunction

  // True when a byte address falls in the word of a register offset
  function automatic logic atfs_sel(input logic [ADDR_W-1:0] addr,
                                    input logic [11:0]       ofs);
    return {addr[ADDR_W-1:2], 2'h0} == ADDR_W'(ofs);
  endfunction

  // ****************************************************************
  // Registers and bus state
  // ****************************************************************
  logic [31:0]       config_q;
  logic [31:0]       gpout_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              have_aw_q;
  logic              have_w_q;
  logic [3:0]        term_out_q;
  logic [3:0]        term_oe_q;
  logic              term0_q;
  logic              slowdown_n_q;
  logic [3:0]        pin_sync;

  wire [3:0] pin_raw = {multi_terminal_7_in, multi_terminal_6_in,
                        multi_terminal_5_in, multi_terminal_4_in};
  wire [3:0] hits    = {compare5_hit, compare4_hit, compare3_hit, compare2_hit};

  atfs_sync #(
    .WIDTH (4)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .aclk_en  (aclk_en),
    .async_in (pin_raw),
    .sync_out (pin_sync)
  );

  // ****************************************************************
  // AXI4-Lite decode
  // ****************************************************************
  wire aw_hs  = s_axi_awvalid & s_axi_awready;
  wire w_hs   = s_axi_wvalid & s_axi_wready;
  wire b_hs   = s_axi_bvalid & s_axi_bready;
  wire ar_hs  = s_axi_arvalid & s_axi_arready;
  wire r_hs   = s_axi_rvalid & s_axi_rready;
  wire do_wr  = have_aw_q & have_w_q & ~s_axi_bvalid;

  wire wsel_config = atfs_sel(waddr_q, `ATFS_OFS_CONFIG);
  wire wsel_gpout  = atfs_sel(waddr_q, `ATFS_OFS_GPOUT);
  wire wsel_status = atfs_sel(waddr_q, `ATFS_OFS_STATUS);
  wire rsel_config = atfs_sel(s_axi_araddr, `ATFS_OFS_CONFIG);
  wire rsel_gpout  = atfs_sel(s_axi_araddr, `ATFS_OFS_GPOUT);
  wire rsel_status = atfs_sel(s_axi_araddr, `ATFS_OFS_STATUS);

  wire [31:0] status_word = {20'h0_0000, term_oe_q, term_out_q, pin_sync};

  wire [31:0] config_d = atfs_merge(config_q, wdata_q, wstrb_q, `ATFS_CONFIG_MASK);
  wire [31:0] gpout_d  = atfs_merge(gpout_q, wdata_q, wstrb_q, `ATFS_GPOUT_MASK);

  wire [31:0] rdata_d = rsel_config ? config_q :
                        rsel_gpout  ? gpout_q  :
                        rsel_status ? status_word : 32'h0000_0000;
  wire        rhit    = rsel_config | rsel_gpout | rsel_status;
  wire        whit    = wsel_config | wsel_gpout | wsel_status;

  // ****************************************************************
  // Write channel
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      have_aw_q     <= 1'b0;
      have_w_q      <= 1'b0;
      waddr_q       <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ATFS_RESP_OKAY;
    end else if (aclk_en) begin
      if (aw_hs) begin
        waddr_q       <= s_axi_awaddr;
        have_aw_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        have_w_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        have_aw_q    <= 1'b0;
        have_w_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= whit ? `ATFS_RESP_OKAY : `ATFS_RESP_SLVERR;
      end
      if (b_hs) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_q <= `ATFS_CONFIG_RST;
      gpout_q  <= `ATFS_GPOUT_RST;
    end else if (aclk_en && do_wr) begin
      if (wsel_config) begin
        config_q <= config_d;
      end
      if (wsel_gpout) begin
        gpout_q <= gpout_d;
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ATFS_RESP_OKAY;
    end else if (aclk_en) begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdata_d;
        s_axi_rresp   <= rhit ? `ATFS_RESP_OKAY : `ATFS_RESP_SLVERR;
      end
      if (r_hs) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Terminal drive
  // ****************************************************************
  for (genvar i = 0; i < 4; i++) begin : g_term
    wire [1:0] drive = atfs_drive(atfs_func_t'(config_q[SEL_LSB[i] +: 2]),
                                  gpout_q[i], hits[i]);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        term_oe_q[i]  <= 1'b0;
        term_out_q[i] <= 1'b0;
      end else if (aclk_en) begin
        term_oe_q[i]  <= drive[1];
        term_out_q[i] <= drive[0];
      end
    end
  end

  wire term0_src = term0_oneshot_mode ? oneshot_pulse : accelerating_indicator;
  wire sel4_in   = (atfs_func_t'(config_q[`ATFS_SEL4_LSB +: 2]) == ATFS_GP_IN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term0_q      <= 1'b1;
      slowdown_n_q <= 1'b1;
    end else if (aclk_en) begin
      term0_q      <= config_q[`ATFS_POL0_BIT] ? term0_src : ~term0_src;
      slowdown_n_q <= sel4_in ? pin_sync[0] : 1'b1;
    end
  end

  assign multi_terminal_0_out = term0_q;
  assign multi_terminal_4_out = term_out_q[0];
  assign multi_terminal_4_oe  = term_oe_q[0];
  assign multi_terminal_5_out = term_out_q[1];
  assign multi_terminal_5_oe  = term_oe_q[1];
  assign multi_terminal_6_out = term_out_q[2];
  assign multi_terminal_6_oe  = term_oe_q[2];
  assign multi_terminal_7_out = term_out_q[3];
  assign multi_terminal_7_oe  = term_oe_q[3];
  assign slowdown_input_n     = slowdown_n_q;

endmodule

`default_nettype wire

/* File: tb/atfs_pin_model.sv */
/* Outside circuitry on terminals 4 to 7.
   Assumes the bench supplies the level each pin takes when released. */
`timescale 1ns/1ps
`default_nettype none
module atfs_pin_model (
  input  wire logic [3:0] out,
  input  wire logic [3:0] oe,
  input  wire logic [3:0] ext,
  output var  logic [3:0] pin
);
  // Outside drives its own level on a pin the device has released
  assign pin = (oe & out) | (~oe & ext);
endmodule
`default_nettype wire

/* File: tb/atfs_props.sv */
/* Port checker for the terminal function select block.
   Assumes one clock aclk and synchronous active-low aresetn. */
`timescale 1ns/1ps
`default_nettype none
module atfs_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        aclk_en,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        multi_terminal_0_out,
  input wire logic        multi_terminal_4_oe,
  input wire logic        slowdown_input_n
);
  // *****
  // Checks
  // *****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_state_a: assert property (disable iff (1'h0)
    !aresetn |=> !multi_terminal_4_oe && multi_terminal_0_out && slowdown_input_n && s_axi_awready)
    else $error("state after reset wrong");
  hold_frozen_a: assert property ((!aclk_en && aresetn) |=>
    $stable({s_axi_bvalid, s_axi_rvalid, multi_terminal_4_oe, multi_terminal_0_out, slowdown_input_n}))
    else $error("outputs moved with clock enable low");
  aw_lock_a: assert property ((aclk_en && s_axi_awvalid && s_axi_awready) |=> !s_axi_awready)
    else $error("write address ready stayed high");
  w_lock_a: assert property ((aclk_en && s_axi_wvalid && s_axi_wready) |=> !s_axi_wready)
    else $error("write data ready stayed high");
  write_answer_a: assert property ((aclk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready ##1 aclk_en) |-> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property ((aclk_en && s_axi_arvalid && s_axi_arready) |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  b_hold_a: assert property ((s_axi_bvalid && !(s_axi_bready && aclk_en)) |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property ((s_axi_rvalid && !(s_axi_rready && aclk_en)) |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  slow_pass_a: assert property (
    multi_terminal_4_oe |-> slowdown_input_n) else $error("slowdown seen while terminal 4 driven");
endmodule
bind atfs_top atfs_props i_props (.*);
`default_nettype wire

/* File: tb/tb_top.sv */
/* Self-checking bench for the terminal function select block.
   Assumes the design, its package, its map header and the pin model. */
`timescale 1ns/1ps
`default_nettype none
`include "atfs_map.svh"
module tb_top;
  import atfs_pkg::*;
  logic        aclk, aresetn, aclk_en, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, acc, osp, osm, t0_out, slow_n, src;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, cfg;
  logic [3:0]  wstrb, hit, ext, eoe, epin, gp;
  logic [1:0]  bresp, rresp, md;
  wire  [3:0]  pin, t_out, t_oe;
  int          failures, compares;

  atfs_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .compare2_hit(hit[0]), .compare3_hit(hit[1]), .compare4_hit(hit[2]), .compare5_hit(hit[3]),
    .accelerating_indicator(acc), .oneshot_pulse(osp), .term0_oneshot_mode(osm),
    .multi_terminal_0_out(t0_out), .slowdown_input_n(slow_n),
    .multi_terminal_4_in(pin[0]), .multi_terminal_4_out(t_out[0]), .multi_terminal_4_oe(t_oe[0]),
    .multi_terminal_5_in(pin[1]), .multi_terminal_5_out(t_out[1]), .multi_terminal_5_oe(t_oe[1]),
    .multi_terminal_6_in(pin[2]), .multi_terminal_6_out(t_out[2]), .multi_terminal_6_oe(t_oe[2]),
    .multi_terminal_7_in(pin[3]), .multi_terminal_7_out(t_out[3]), .multi_terminal_7_oe(t_oe[3])
  );
  atfs_pin_model i_pins (.out(t_out), .oe(t_oe), .ext(ext), .pin(pin));

  // *****
  // Check, report and bus tasks
  // *****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tmo(input logic ok);
    if (ok !== 1'h1) begin
      failures++;
      final_report();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      n++;
    end while (!bvalid && n < 40);
    bready <= 1'h0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    tmo(bvalid);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      n++;
    end while (!rvalid && n < 40);
    rready <= 1'h0;
    d = rdata;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    tmo(rvalid);
    @(posedge aclk);
  endtask

  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  // *****
  // Scenarios
  // *****
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, acc, osp, osm} = '0;
    {awaddr, araddr, wdata, wstrb, hit, cfg, failures, compares} = '0;
    aclk_en = 1'h1;
    ext = 4'hA;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    chk("oe idle", {28'h0, t_oe}, 32'h0);
    chk("slowdown", {31'h0, slow_n}, 32'h0);
    rd(`ATFS_OFS_STATUS, `ATFS_RESP_OKAY);
    chk("status idle", d, 32'h0000_000A);
    wr(`ATFS_OFS_GPOUT, 32'h0000_0006, 4'hF, `ATFS_RESP_OKAY);
    gp = 4'h6;
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 4; i++) cfg[8+2*i +: 2] = 2'(m + i);
      wr(`ATFS_OFS_CONFIG, cfg, 4'hF, `ATFS_RESP_OKAY);
      for (int h = 0; h < 2; h++) begin
        hit <= h ? 4'hA : 4'h5;
        ext <= h ? 4'h5 : 4'hA;
        repeat (4) @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
          md = cfg[8+2*i +: 2];
          eoe[i] = (md != 2'h0);
          epin[i] = md == 2'h0 ? ext[i] : md == 2'h1 ? gp[i] : md == 2'h2 ? ~hit[i] : hit[i];
        end
        chk("oe", {28'h0, t_oe}, {28'h0, eoe});
        chk("pins", {28'h0, pin}, {28'h0, epin});
        chk("slowdown", {31'h0, slow_n}, {31'h0, cfg[`ATFS_SEL4_LSB +: 2] == 2'h0 ? ext[0] : 1'h1});
        rd(`ATFS_OFS_STATUS, `ATFS_RESP_OKAY);
        chk("status", d, {20'h0, eoe, eoe & epin, epin});
      end
    end
    for (int k = 0; k < 8; k++) begin
      wr(`ATFS_OFS_CONFIG, {15'h0, k[2], 16'h0}, 4'hF, `ATFS_RESP_OKAY);
      osm <= k[1];
      acc <= k[0];
      osp <= ~k[0];
      repeat (3) @(posedge aclk);
      src = k[1] ? ~k[0] : k[0];
      chk("term0", {31'h0, t0_out}, {31'h0, k[2] ? src : ~src});
    end
    wr(`ATFS_OFS_CONFIG, 32'hFFFF_FFFF, 4'hF, `ATFS_RESP_OKAY);
    rd(`ATFS_OFS_CONFIG, `ATFS_RESP_OKAY);
    chk("config mask", d, `ATFS_CONFIG_MASK);
    wr(`ATFS_OFS_CONFIG, 32'h0, 4'h2, `ATFS_RESP_OKAY);
    rd(`ATFS_OFS_CONFIG, `ATFS_RESP_OKAY);
    chk("config strobe", d, 32'h0001_0000);
    wr(`ATFS_OFS_STATUS, 32'hFFFF_FFFF, 4'hF, `ATFS_RESP_OKAY);
    wr(12'h00C, 32'hFFFF_FFFF, 4'hF, `ATFS_RESP_SLVERR);
    rd(12'h00C, `ATFS_RESP_SLVERR);
    chk("unmapped", d, 32'h0);
    wr(`ATFS_OFS_CONFIG, 32'h0000_FF00, 4'hF, `ATFS_RESP_OKAY);
    hit <= 4'h3;
    repeat (3) @(posedge aclk);
    aclk_en <= 1'h0;
    hit <= 4'hC;
    repeat (3) @(posedge aclk);
    chk("held", {28'h0, t_out}, 32'h3);
    aclk_en <= 1'h1;
    repeat (3) @(posedge aclk);
    chk("hit high", {28'h0, t_out}, 32'hC);
    // Reset in mid-run while every terminal is driven
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (int e = 0; e < 2; e++) begin
      @(posedge aclk);
      chk("reset oe", {28'h0, t_oe}, 32'h0);
      chk("reset slowdown", {31'h0, slow_n}, 32'h1);
      chk("reset term0", {31'h0, t0_out}, 32'h1);
    end
    rd(`ATFS_OFS_CONFIG, `ATFS_RESP_OKAY);
    chk("reset config", d, `ATFS_CONFIG_RST);
    final_report();
  end
endmodule
`default_nettype wire
